// file: rtl/bram_params.svh
// constants for the dual-port block memory: geometry, config register map,
// field positions and reset values.
// assumes it is included by bare name wherever these names are needed.
`ifndef BRAM_PARAMS_SVH
`define BRAM_PARAMS_SVH

// ----------------------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------------------
`define BRAM_ADDR_W 9
`define BRAM_DEPTH 512
`define BRAM_DATA_W 32
`define BRAM_PAR_W 4
`define BRAM_WORD_W 36
`define BRAM_DATA_BITS 16384
`define BRAM_PAR_BITS 2048

// ----------------------------------------------------------------------------
// config register map (byte addresses on the apb bus)
// ----------------------------------------------------------------------------
`define APB_ADDR_W 8
`define APB_DATA_W 32
`define REG_CTRL 8'h00
`define REG_SR_A_DATA 8'h04
`define REG_SR_A_PAR 8'h08
`define REG_SR_B_DATA 8'h0c
`define REG_SR_B_PAR 8'h10
`define REG_STATUS 8'h14

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define MODE_W 2
`define CTRL_MODE_A_LSB 0
`define CTRL_MODE_B_LSB 2
`define STATUS_COLL_A 0
`define STATUS_COLL_B 1
`define SR_RST_DATA 32'h0000_0000
`define SR_RST_PAR 4'h0

`endif

// file: rtl/bram_pkg.sv
// types shared by the dual-port block memory files.
// assumes bram_params.svh sits beside this file.
`include "bram_params.svh"

package bram_pkg;

  // output latch behaviour during a write
  typedef enum logic [`MODE_W-1:0] {
    WM_WRITE_FIRST,
    WM_READ_FIRST,
    WM_NO_CHANGE
  } write_mode_t;

  // state of the top: config registers, collision flags, apb answer
  typedef struct packed {
    write_mode_t mode_a;
    write_mode_t mode_b;
    logic [`BRAM_DATA_W-1:0] sr_a_data;
    logic [`BRAM_PAR_W-1:0] sr_a_par;
    logic [`BRAM_DATA_W-1:0] sr_b_data;
    logic [`BRAM_PAR_W-1:0] sr_b_par;
    logic coll_a;
    logic coll_b;
    logic [`APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } top_state_t;

  // the two output latches of the memory
  typedef struct packed {
    logic [`BRAM_WORD_W-1:0] q_a;
    logic [`BRAM_WORD_W-1:0] q_b;
  } latch_state_t;

endpackage : bram_pkg

// file: rtl/bram_mem.sv
// storage array of the block memory with its two output latches.
// assumes one clock for both ports; both addresses are stable at the edge.
`timescale 1ns/1ns
`include "bram_params.svh"

module bram_mem
  import bram_pkg::*;
#(
  parameter logic [`BRAM_DATA_BITS-1:0] DATA_INIT = '0,
  parameter logic [`BRAM_PAR_BITS-1:0] PAR_INIT = '0,
  parameter logic [`BRAM_WORD_W-1:0] INIT_A = '0,
  parameter logic [`BRAM_WORD_W-1:0] INIT_B = '0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_we_a,
  input wire logic [`BRAM_ADDR_W-1:0] i_addr_a,
  input wire logic [`BRAM_WORD_W-1:0] i_wdata_a,
  input wire logic i_rd_a,
  input wire logic i_ld_a,
  input wire logic [`BRAM_WORD_W-1:0] i_val_a,
  input wire logic i_we_b,
  input wire logic [`BRAM_ADDR_W-1:0] i_addr_b,
  input wire logic [`BRAM_WORD_W-1:0] i_wdata_b,
  input wire logic i_rd_b,
  input wire logic i_ld_b,
  input wire logic [`BRAM_WORD_W-1:0] i_val_b,
  output logic [`BRAM_WORD_W-1:0] o_q_a,
  output logic [`BRAM_WORD_W-1:0] o_q_b
);

  logic [`BRAM_WORD_W-1:0] mem [0:`BRAM_DEPTH-1];
  latch_state_t st;
  latch_state_t next_st;

  // configuration-time contents: each word takes its slice of the strings
  initial begin
    for (int i = 0; i < `BRAM_DEPTH; i++) begin
      mem[i] = {PAR_INIT[i*`BRAM_PAR_W +: `BRAM_PAR_W],
                DATA_INIT[i*`BRAM_DATA_W +: `BRAM_DATA_W]};
    end
  end

  // writes; on a same-address clash port b lands last and wins
  always_ff @(posedge i_clk) begin
    if (i_we_a) begin
      mem[i_addr_a] <= i_wdata_a;
    end
    if (i_we_b) begin
      mem[i_addr_b] <= i_wdata_b;
    end
  end

  // latches read the array before this edge's writes land
  always_comb begin
    next_st = st;
    if (i_sys_rst) begin
      next_st.q_a = INIT_A;
      next_st.q_b = INIT_B;
    end else begin
      if (i_rd_a) begin
        next_st.q_a = mem[i_addr_a];
      end else if (i_ld_a) begin
        next_st.q_a = i_val_a;
      end
      if (i_rd_b) begin
        next_st.q_b = mem[i_addr_b];
      end else if (i_ld_b) begin
        next_st.q_b = i_val_b;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_q_a = st.q_a;
  assign o_q_b = st.q_b;

endmodule : bram_mem

// file: rtl/bram_port_ctl.sv
// per-port decision of what the output latch does at the coming edge.
// assumes it is purely combinational and used once per port.
`timescale 1ns/1ns
`include "bram_params.svh"

module bram_port_ctl
  import bram_pkg::*;
(
  input wire logic i_en,
  input wire logic i_setreset,
  input wire logic i_we,
  input wire write_mode_t i_mode,
  output logic o_rd,
  output logic o_ld
);

  // priority: disabled, set/reset, read, then write mode
  always_comb begin
    o_rd = 1'b0;
    o_ld = 1'b0;
    if (!i_en) begin
      o_rd = 1'b0;
    end else if (i_setreset) begin
      o_ld = 1'b1;
    end else if (!i_we) begin
      o_rd = 1'b1;
    end else begin
      case (i_mode)
        WM_WRITE_FIRST: o_ld = 1'b1;
        WM_READ_FIRST: o_rd = 1'b1;
        WM_NO_CHANGE: o_rd = 1'b0;
        default: o_ld = 1'b1; // unused code acts as write-first
      endcase
    end
  end

endmodule : bram_port_ctl

// file: rtl/bram_dual_port.sv
// dual-port block memory: two independent ports, apb config registers.
// assumes both ports and the apb bus run on i_clk; inputs synchronous.
//
// Function
// - The data array is preloaded at configuration from init strings filling all 16384 bits.
// - The parity array is preloaded likewise from its own strings filling 2048 bits.
// - Global set/reset puts each port's configured initial value on its latches, memory kept.
// - Each port has its own set/reset value loaded by its synchronous set/reset.
// - Each port selects write-first, read-first or no-change for its latches during a write.
// - Reads and writes happen on the clock edge and the two ports act independently.
// - Enable with write enable stores data and parity in at the addressed word.
// - Enable without write enable loads the addressed word into the latches, memory kept.
// - In write-first mode a write also shows the new word on the same port's outputs.
// - In read-first mode a write shows the old word first and then overwrites it.
// - In no-change mode a write leaves the outputs as they were but still updates memory.
// - A write to the address the other port uses invalidates it unless read-first; here its outputs are not forced to x and its STATUS flag is set.
// - With enable low a port neither reads nor writes and its outputs stay put.
// - Set/reset acts on an enabled edge and forces the latches to the set/reset value.
// - While enabled the address must be stable around the edge even if unused.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "bram_params.svh"

module bram_dual_port
  import bram_pkg::*;
#(
  parameter logic [`BRAM_DATA_BITS-1:0] DATA_INIT_STRINGS = '0,
  parameter logic [`BRAM_PAR_BITS-1:0] PARITY_INIT_STRINGS = '0,
  parameter logic [`BRAM_WORD_W-1:0] PORT_A_OUTPUT_INITIAL_VALUE = '0,
  parameter logic [`BRAM_WORD_W-1:0] PORT_B_OUTPUT_INITIAL_VALUE = '0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`APB_ADDR_W-1:0] i_paddr,
  input wire logic [`APB_DATA_W-1:0] i_pwdata,
  output logic [`APB_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_en_a,
  input wire logic i_we_a,
  input wire logic i_setreset_a,
  input wire logic [`BRAM_ADDR_W-1:0] i_addr_a,
  input wire logic [`BRAM_DATA_W-1:0] i_data_in_bus_a,
  input wire logic [`BRAM_PAR_W-1:0] i_parity_in_bus_a,
  output logic [`BRAM_DATA_W-1:0] o_data_out_a,
  output logic [`BRAM_PAR_W-1:0] o_parity_out_bus_a,
  input wire logic i_en_b,
  input wire logic i_we_b,
  input wire logic i_setreset_b,
  input wire logic [`BRAM_ADDR_W-1:0] i_addr_b,
  input wire logic [`BRAM_DATA_W-1:0] i_data_in_bus_b,
  input wire logic [`BRAM_PAR_W-1:0] i_parity_in_bus_b,
  output logic [`BRAM_DATA_W-1:0] o_data_out_b,
  output logic [`BRAM_PAR_W-1:0] o_parity_out_bus_b
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  top_state_t st;
  top_state_t next_st;
  logic rd_a;
  logic ld_a;
  logic rd_b;
  logic ld_b;
  logic wr_a;
  logic wr_b;
  logic [`BRAM_WORD_W-1:0] wdata_a;
  logic [`BRAM_WORD_W-1:0] wdata_b;
  logic [`BRAM_WORD_W-1:0] val_a;
  logic [`BRAM_WORD_W-1:0] val_b;
  logic [`BRAM_WORD_W-1:0] q_a;
  logic [`BRAM_WORD_W-1:0] q_b;
  logic same_addr;
  logic coll_a_evt;
  logic coll_b_evt;
  logic apb_setup;
  logic apb_wr;

  // decode an apb offset to a known register
  function automatic logic reg_hit(input logic [`APB_ADDR_W-1:0] addr);
    reg_hit = (addr == `REG_CTRL) || (addr == `REG_SR_A_DATA) ||
              (addr == `REG_SR_A_PAR) || (addr == `REG_SR_B_DATA) ||
              (addr == `REG_SR_B_PAR) || (addr == `REG_STATUS);
  endfunction : reg_hit

  // a written mode field; the spare code is kept and acts as write-first
  function automatic write_mode_t mode_of(input logic [`MODE_W-1:0] bits);
    mode_of = write_mode_t'(bits);
  endfunction : mode_of

  // --------------------------------------------------------------------------
  // port datapath
  // --------------------------------------------------------------------------
  // the address is used as sampled at the edge; the user keeps it stable
  assign wr_a = i_en_a && i_we_a;
  assign wr_b = i_en_b && i_we_b;
  assign wdata_a = {i_parity_in_bus_a, i_data_in_bus_a};
  assign wdata_b = {i_parity_in_bus_b, i_data_in_bus_b};

  // forced value: set/reset value wins over the write-first pass-through
  assign val_a = i_setreset_a ? {st.sr_a_par, st.sr_a_data} : wdata_a;
  assign val_b = i_setreset_b ? {st.sr_b_par, st.sr_b_data} : wdata_b;

  bram_port_ctl u_ctl_a (
    .i_en(i_en_a),
    .i_setreset(i_setreset_a),
    .i_we(i_we_a),
    .i_mode(st.mode_a),
    .o_rd(rd_a),
    .o_ld(ld_a)
  );

  bram_port_ctl u_ctl_b (
    .i_en(i_en_b),
    .i_setreset(i_setreset_b),
    .i_we(i_we_b),
    .i_mode(st.mode_b),
    .o_rd(rd_b),
    .o_ld(ld_b)
  );

  // write still happens under set/reset; only the latches take the value
  bram_mem #(
    .DATA_INIT(DATA_INIT_STRINGS),
    .PAR_INIT(PARITY_INIT_STRINGS),
    .INIT_A(PORT_A_OUTPUT_INITIAL_VALUE),
    .INIT_B(PORT_B_OUTPUT_INITIAL_VALUE)
  ) u_mem (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_we_a(wr_a),
    .i_addr_a(i_addr_a),
    .i_wdata_a(wdata_a),
    .i_rd_a(rd_a),
    .i_ld_a(ld_a),
    .i_val_a(val_a),
    .i_we_b(wr_b),
    .i_addr_b(i_addr_b),
    .i_wdata_b(wdata_b),
    .i_rd_b(rd_b),
    .i_ld_b(ld_b),
    .i_val_b(val_b),
    .o_q_a(q_a),
    .o_q_b(q_b)
  );

  // outputs come straight from the latch flops in the memory
  assign o_data_out_a = q_a[`BRAM_DATA_W-1:0];
  assign o_parity_out_bus_a = q_a[`BRAM_WORD_W-1:`BRAM_DATA_W];
  assign o_data_out_b = q_b[`BRAM_DATA_W-1:0];
  assign o_parity_out_bus_b = q_b[`BRAM_WORD_W-1:`BRAM_DATA_W];

  // --------------------------------------------------------------------------
  // same-address collisions
  // --------------------------------------------------------------------------
  // the reader's outputs are not forced to x; the flag tells software instead
  assign same_addr = (i_addr_a == i_addr_b);
  assign coll_a_evt = wr_b && i_en_a && same_addr && (st.mode_b != WM_READ_FIRST);
  assign coll_b_evt = wr_a && i_en_b && same_addr && (st.mode_a != WM_READ_FIRST);

  // --------------------------------------------------------------------------
  // apb slave and config registers
  // --------------------------------------------------------------------------
  // zero wait: the answer is registered in the setup cycle
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr = i_psel && i_penable && st.pready && i_pwrite;

  always_comb begin
    next_st = st;
    next_st.pready = apb_setup;
    next_st.pslverr = apb_setup && !reg_hit(i_paddr);
    next_st.prdata = '0;
    if (apb_setup && !i_pwrite) begin
      case (i_paddr)
        `REG_CTRL: begin
          next_st.prdata[`CTRL_MODE_A_LSB +: `MODE_W] = st.mode_a;
          next_st.prdata[`CTRL_MODE_B_LSB +: `MODE_W] = st.mode_b;
        end
        `REG_SR_A_DATA: next_st.prdata = st.sr_a_data;
        `REG_SR_A_PAR: next_st.prdata[`BRAM_PAR_W-1:0] = st.sr_a_par;
        `REG_SR_B_DATA: next_st.prdata = st.sr_b_data;
        `REG_SR_B_PAR: next_st.prdata[`BRAM_PAR_W-1:0] = st.sr_b_par;
        `REG_STATUS: begin
          next_st.prdata[`STATUS_COLL_A] = st.coll_a;
          next_st.prdata[`STATUS_COLL_B] = st.coll_b;
        end
        default: next_st.prdata = '0;
      endcase
    end
    // register writes take effect only at the access edge
    if (apb_wr) begin
      case (i_paddr)
        `REG_CTRL: begin
          next_st.mode_a = mode_of(i_pwdata[`CTRL_MODE_A_LSB +: `MODE_W]);
          next_st.mode_b = mode_of(i_pwdata[`CTRL_MODE_B_LSB +: `MODE_W]);
        end
        `REG_SR_A_DATA: next_st.sr_a_data = i_pwdata;
        `REG_SR_A_PAR: next_st.sr_a_par = i_pwdata[`BRAM_PAR_W-1:0];
        `REG_SR_B_DATA: next_st.sr_b_data = i_pwdata;
        `REG_SR_B_PAR: next_st.sr_b_par = i_pwdata[`BRAM_PAR_W-1:0];
        `REG_STATUS: begin
          if (i_pwdata[`STATUS_COLL_A]) begin
            next_st.coll_a = 1'b0;
          end
          if (i_pwdata[`STATUS_COLL_B]) begin
            next_st.coll_b = 1'b0;
          end
        end
        default: next_st.coll_a = st.coll_a;
      endcase
    end
    // a collision in the clearing cycle is kept: set beats clear
    if (coll_a_evt) begin
      next_st.coll_a = 1'b1;
    end
    if (coll_b_evt) begin
      next_st.coll_b = 1'b1;
    end
    if (i_sys_rst) begin
      next_st.mode_a = WM_WRITE_FIRST;
      next_st.mode_b = WM_WRITE_FIRST;
      next_st.sr_a_data = `SR_RST_DATA;
      next_st.sr_a_par = `SR_RST_PAR;
      next_st.sr_b_data = `SR_RST_DATA;
      next_st.sr_b_par = `SR_RST_PAR;
      next_st.coll_a = 1'b0;
      next_st.coll_b = 1'b0;
      next_st.prdata = '0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // a clean port a write with no port b write in the same cycle
  sequence s_wr_a;
    wr_a && !i_setreset_a && !wr_b;
  endsequence

  // a port a read of the address written one cycle before
  sequence s_rd_same_a;
    i_en_a && !i_we_a && !i_setreset_a && !wr_b && (i_addr_a == $past(i_addr_a));
  endsequence

  // a read-first write of the address written one cycle before
  sequence s_rf_same_a;
    wr_a && !i_setreset_a && !wr_b && (st.mode_a == WM_READ_FIRST) &&
      (i_addr_a == $past(i_addr_a));
  endsequence

  AST_DISABLED_HOLD: assert property (
    !i_en_a |=> $stable(o_data_out_a) && $stable(o_parity_out_bus_a))
    else $error("port a outputs moved while disabled");

  AST_WRITE_THEN_READ: assert property (
    s_wr_a ##1 s_rd_same_a |=> q_a == $past(wdata_a, 2))
    else $error("port a read did not return the word just written");

  AST_READ_FIRST_OLD: assert property (
    s_wr_a ##1 s_rf_same_a |=> q_a == $past(wdata_a, 2))
    else $error("read-first write did not show the old word");

  AST_WRITE_FIRST_NEW: assert property (
    wr_a && !i_setreset_a && st.mode_a == WM_WRITE_FIRST |=> q_a == $past(wdata_a))
    else $error("write-first write did not show the new word");

  AST_NO_CHANGE_HOLD: assert property (
    wr_a && !i_setreset_a && st.mode_a == WM_NO_CHANGE |=> $stable(q_a))
    else $error("no-change write moved the outputs");

  AST_SETRESET_A: assert property (
    i_en_a && i_setreset_a |=> q_a == $past({st.sr_a_par, st.sr_a_data}))
    else $error("port a set/reset value not loaded");

  AST_SETRESET_WRITE: assert property (
    (wr_a && i_setreset_a && !wr_b) ##1 s_rd_same_a |=> q_a == $past(wdata_a, 2))
    else $error("write under set/reset did not reach memory");

  AST_SETRESET_B: assert property (
    i_en_b && i_setreset_b && !(i_en_a && i_setreset_a) |=>
      q_b == $past({st.sr_b_par, st.sr_b_data}))
    else $error("port b set/reset value not loaded");

  AST_COLLISION_FLAG: assert property (
    coll_a_evt |=> st.coll_a)
    else $error("collision on port a not flagged");

endmodule : bram_dual_port

// file: tb/bram_port_user.sv
// user logic model for one memory port: enable, controls, address, write word.
// assumes the bench calls op from its main sequence; everything runs on i_clk.
`timescale 1ns/1ns
`include "bram_params.svh"

module bram_port_user (
  input wire logic i_clk,
  output logic o_en,
  output logic o_we,
  output logic o_setreset,
  output logic [`BRAM_ADDR_W-1:0] o_addr,
  output logic [`BRAM_DATA_W-1:0] o_data,
  output logic [`BRAM_PAR_W-1:0] o_par
);
  // idle at time zero
  initial begin
    o_en = 1'b0;
    o_we = 1'b0;
    o_setreset = 1'b0;
    o_addr = '0;
    o_data = '0;
    o_par = '0;
  end

  // one enabled cycle; the address stays put until the sampling edge
  task automatic op(input logic we, input logic sr, input logic [8:0] a,
                    input logic [35:0] d);
    @(posedge i_clk);
    o_en <= 1'b1;
    o_we <= we;
    o_setreset <= sr;
    o_addr <= a;
    {o_par, o_data} <= d;
    @(posedge i_clk);
    // released lines flip so a stale value is never mistaken for a request
    o_en <= 1'b0;
    o_we <= ~we;
    o_setreset <= ~sr;
    o_addr <= ~a;
    {o_par, o_data} <= ~d;
  endtask : op
endmodule : bram_port_user

// file: tb/dual_port_block_ram_test.sv
// self-checking bench for the dual-port block memory.
// assumes bram_port_user drives both ports and the bench is the apb master.
`timescale 1ns/1ns
`include "bram_params.svh"

module dual_port_block_ram_test
  import bram_pkg::*;
;
  // ----------------------------------------------------------------------------
  // preload images: word i holds c0de_0000 + i, parity i[3:0]
  // ----------------------------------------------------------------------------
  function automatic logic [`BRAM_DATA_BITS-1:0] data_img();
    logic [`BRAM_DATA_BITS-1:0] img;
    img = '0;
    for (int i = 0; i < `BRAM_DEPTH; i++) begin
      img[i*32+:32] = 32'hc0de_0000 | 32'(i);
    end
    return img;
  endfunction : data_img

  function automatic logic [`BRAM_PAR_BITS-1:0] par_img();
    logic [`BRAM_PAR_BITS-1:0] img;
    for (int i = 0; i < `BRAM_DEPTH; i++) begin
      img[i*4+:4] = 4'(i);
    end
    return img;
  endfunction : par_img

  localparam logic [35:0] INIT_A = 36'h9_1234_5678;
  localparam logic [35:0] INIT_B = 36'h6_8765_4321;
  localparam logic [35:0] SR_A = 36'h7_5555_aaaa;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic en_a, we_a, sr_a, en_b, we_b, sr_b;
  logic [8:0] addr_a, addr_b;
  logic [31:0] din_a, din_b, dout_a, dout_b;
  logic [3:0] pin_a, pin_b, pout_a, pout_b;
  int n_errors = 0;
  int checked = 0;

  always #10 clk = ~clk;

  bram_port_user u_port_a (.i_clk(clk), .o_en(en_a), .o_we(we_a), .o_setreset(sr_a),
    .o_addr(addr_a), .o_data(din_a), .o_par(pin_a));
  bram_port_user u_port_b (.i_clk(clk), .o_en(en_b), .o_we(we_b), .o_setreset(sr_b),
    .o_addr(addr_b), .o_data(din_b), .o_par(pin_b));

  bram_dual_port #(.DATA_INIT_STRINGS(data_img()), .PARITY_INIT_STRINGS(par_img()),
    .PORT_A_OUTPUT_INITIAL_VALUE(INIT_A), .PORT_B_OUTPUT_INITIAL_VALUE(INIT_B))
  u_bram_dual_port (.i_clk(clk), .i_sys_rst(sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_en_a(en_a), .i_we_a(we_a),
    .i_setreset_a(sr_a), .i_addr_a(addr_a), .i_data_in_bus_a(din_a),
    .i_parity_in_bus_a(pin_a), .o_data_out_a(dout_a), .o_parity_out_bus_a(pout_a),
    .i_en_b(en_b), .i_we_b(we_b), .i_setreset_b(sr_b), .i_addr_b(addr_b),
    .i_data_in_bus_b(din_b), .i_parity_in_bus_b(pin_b), .o_data_out_b(dout_b),
    .o_parity_out_bus_b(pout_b));

  // ----------------------------------------------------------------------------
  // checking and apb tasks
  // ----------------------------------------------------------------------------
  task automatic conclude();
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // zero-wait slave, but the wait is bounded rather than assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // look at pready once settled, so the edge that ends the access is the next one
    #1;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (pready !== 1'b1) begin
      n_errors++;
      conclude();
    end
    // answer stands until the closing edge; taken as it is sampled there
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : reg_wr

  task automatic reg_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                         input logic e_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, '0, rd, err);
    chk(nm, {4'h0, e}, {4'h0, rd});
    chk({nm, "_err"}, {35'h0, e_err}, {35'h0, err});
  endtask : reg_chk

  // ----------------------------------------------------------------------------
  // port a cases: mode, write, set/reset, address, word in, word expected
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic we;
    logic sr;
    logic [8:0] a;
    logic [35:0] d;
    logic [35:0] q;
  } row_t;

  row_t rows [12] = '{
    '{2'd0, 1'b0, 1'b0, 9'd5, 36'h0, 36'h5_c0de_0005},
    '{2'd0, 1'b0, 1'b0, 9'd511, 36'h0, 36'hf_c0de_01ff},
    '{2'd0, 1'b1, 1'b0, 9'd5, 36'h3_aaaa_0001, 36'h3_aaaa_0001},
    '{2'd0, 1'b0, 1'b0, 9'd5, 36'h0, 36'h3_aaaa_0001},
    '{2'd1, 1'b1, 1'b0, 9'd6, 36'h1_bbbb_0002, 36'h6_c0de_0006},
    '{2'd1, 1'b0, 1'b0, 9'd6, 36'h0, 36'h1_bbbb_0002},
    '{2'd2, 1'b1, 1'b0, 9'd7, 36'h2_cccc_0003, 36'h1_bbbb_0002},
    '{2'd2, 1'b0, 1'b0, 9'd7, 36'h0, 36'h2_cccc_0003},
    '{2'd0, 1'b1, 1'b1, 9'd8, 36'h4_dddd_0004, SR_A},
    '{2'd0, 1'b0, 1'b0, 9'd8, 36'h0, 36'h4_dddd_0004},
    '{2'd1, 1'b0, 1'b1, 9'd9, 36'h0, SR_A},
    '{2'd3, 1'b1, 1'b0, 9'd10, 36'h5_eeee_0005, 36'h5_eeee_0005}
  };

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("init_a", INIT_A, {pout_a, dout_a});
    chk("init_b", INIT_B, {pout_b, dout_b});
    reg_chk("ctrl_rst", `REG_CTRL, 32'h0, 1'b0);
    reg_chk("sr_a_rst", `REG_SR_A_DATA, 32'h0, 1'b0);
    reg_wr(`REG_SR_A_DATA, SR_A[31:0]);
    reg_wr(`REG_SR_A_PAR, {28'h0, SR_A[35:32]});
    foreach (rows[i]) begin
      reg_wr(`REG_CTRL, {30'h0, rows[i].mode});
      u_port_a.op(rows[i].we, rows[i].sr, rows[i].a, rows[i].d);
      #1;
      chk("row_q_a", rows[i].q, {pout_a, dout_a});
    end
    // disabled port: released lines show write on, address 9, data all ones
    u_port_a.op(1'b0, 1'b0, 9'd502, 36'h0);
    repeat (3) @(posedge clk);
    #1;
    chk("hold_a", 36'h6_c0de_01f6, {pout_a, dout_a});
    u_port_a.op(1'b0, 1'b0, 9'd9, 36'h0);
    #1;
    chk("kept_a", 36'h9_c0de_0009, {pout_a, dout_a});
    // b writes read-first where a reads: a sees old contents, no flag
    reg_wr(`REG_CTRL, 32'h4);
    fork
      u_port_a.op(1'b0, 1'b0, 9'd20, 36'h0);
      u_port_b.op(1'b1, 1'b0, 9'd20, 36'h8_1111_2222);
    join
    #1;
    chk("rf_a", 36'h4_c0de_0014, {pout_a, dout_a});
    chk("rf_b", 36'h4_c0de_0014, {pout_b, dout_b});
    reg_chk("stat_rf", `REG_STATUS, 32'h0, 1'b0);
    // b writes write-first where a reads: collision on a is flagged
    reg_wr(`REG_CTRL, 32'h0);
    fork
      u_port_a.op(1'b0, 1'b0, 9'd21, 36'h0);
      u_port_b.op(1'b1, 1'b0, 9'd21, 36'h9_3333_4444);
    join
    #1;
    chk("wf_b", 36'h9_3333_4444, {pout_b, dout_b});
    reg_chk("stat_coll", `REG_STATUS, 32'h1, 1'b0);
    reg_wr(`REG_STATUS, 32'h1);
    reg_chk("stat_clr", `REG_STATUS, 32'h0, 1'b0);
    u_port_b.op(1'b0, 1'b0, 9'd5, 36'h0);
    #1;
    chk("b_sees_a", 36'h3_aaaa_0001, {pout_b, dout_b});
    chk("a_untouched", 36'h5_c0de_0015, {pout_a, dout_a});
    reg_chk("unmapped", 8'h18, 32'h0, 1'b1);
    // global reset mid-run: latches back to initial, memory kept
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("rst_a", INIT_A, {pout_a, dout_a});
    chk("rst_b", INIT_B, {pout_b, dout_b});
    @(posedge clk);
    sys_rst <= 1'b0;
    u_port_a.op(1'b0, 1'b0, 9'd5, 36'h0);
    #1;
    chk("mem_kept", 36'h3_aaaa_0001, {pout_a, dout_a});
    reg_chk("sr_a_clr", `REG_SR_A_DATA, 32'h0, 1'b0);
    conclude();
  end
endmodule : dual_port_block_ram_test
